// ---- rtl/oad_decode.sv ----
`timescale 1ns/1ps
module oad_decode
(
    input  wire logic        ref_clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        issue_in,
    input  wire logic [1:0]  iclass_in,
    input  wire logic [2:0]  src_mode_in,
    input  wire logic [2:0]  dst_mode_in,
    input  wire logic [3:0]  src_ptr_in,
    input  wire logic [3:0]  dst_ptr_in,
    input  wire logic [3:0]  offset_register_field_in,
    input  wire logic [15:0] src_lit_in,
    input  wire logic [15:0] dst_lit_in,
    input  wire logic        lit_wide_in,
    input  wire logic        src_dec_in,
    input  wire logic        dst_dec_in,
    input  wire logic [3:0]  pf_ptr0_in,
    input  wire logic [3:0]  pf_ptr1_in,
    input  wire logic [255:0] wreg_in,
    output logic             valid_out,
    output logic             mode_err_out,
    output logic [15:0]      src_ea_out,
    output logic [15:0]      dst_ea_out,
    output logic             src_wb_out,
    output logic [3:0]       src_wb_idx_out,
    output logic [15:0]      src_wb_val_out,
    output logic             dst_wb_out,
    output logic [3:0]       dst_wb_idx_out,
    output logic [15:0]      dst_wb_val_out,
    output logic             x_rd_valid_out,
    output logic [15:0]      x_rd_addr_out,
    output logic             y_rd_valid_out,
    output logic [15:0]      y_rd_addr_out
);
    function automatic logic [15:0] oad_reg(input logic [255:0] f, input logic [3:0] i);
        oad_reg = f[{i, 4'h0} +: 16];
    endfunction : oad_reg

    function automatic logic oad_allowed(input logic [1:0] c, input logic [2:0] m);
        logic [7:0] mask;
        case (c)
            oad_pkg::CLASS_MCU:  mask = oad_pkg::ALLOW_MCU;
            oad_pkg::CLASS_MOVE: mask = oad_pkg::ALLOW_MOVE;
            oad_pkg::CLASS_ACC:  mask = oad_pkg::ALLOW_ACC;
            default:             mask = oad_pkg::ALLOW_DUAL;
        endcase
        oad_allowed = mask[m];
    endfunction : oad_allowed

    function automatic logic oad_is_pf(input logic [3:0] r);
        oad_is_pf = (r >= oad_pkg::PF_PTR_A) && (r <= oad_pkg::PF_PTR_D);
    endfunction : oad_is_pf

    function automatic logic [15:0] oad_lit(input logic [15:0] l, input logic w);
        oad_lit = w ? l : {8'h00, l[7:0]};
    endfunction : oad_lit

    oad_ea_if src_if ();
    oad_ea_if dst_if ();

    // request screening
    wire        is_dual     = (iclass_in == oad_pkg::CLASS_DUAL);
    wire [15:0] ofs_val     = oad_reg(wreg_in, offset_register_field_in);
    wire        src_ok      = oad_allowed(iclass_in, src_mode_in);
    // dual-source words carry no destination mode, so it is not screened
    wire        dst_ok      = is_dual || oad_allowed(iclass_in, dst_mode_in);
    wire        pf0_ok      = oad_is_pf(pf_ptr0_in);
    wire        pf1_ok      = oad_is_pf(pf_ptr1_in);
    wire        pf_ok       = !is_dual || (pf0_ok && pf1_ok);
    wire        all_ok      = src_ok && dst_ok && pf_ok;
    wire        accept      = issue_in && all_ok;
    wire        refuse      = issue_in && !all_ok;

    // bit 1 of an in-range pointer number picks the y side
    wire        pf0_y       = pf_ptr0_in[1];
    wire        pf1_y       = pf_ptr1_in[1];
    wire [15:0] pf0_addr    = oad_reg(wreg_in, pf_ptr0_in);
    wire [15:0] pf1_addr    = oad_reg(wreg_in, pf_ptr1_in);
    // both pointers on one side: only one address per side survives
    wire [15:0] x_addr      = pf0_y ? pf1_addr : pf0_addr;
    wire [15:0] y_addr      = pf0_y ? pf0_addr : pf1_addr;
    wire        x_has       = !pf0_y || !pf1_y;
    wire        y_has       = pf0_y || pf1_y;

    // effective address paths
    wire [15:0] src_ptr_val = oad_reg(wreg_in, src_ptr_in);
    wire [15:0] dst_ptr_val = oad_reg(wreg_in, dst_ptr_in);
    // one width flag for both literals, a mixed-width pair cannot be asked for
    wire [15:0] src_lit_val = oad_lit(src_lit_in, lit_wide_in);
    wire [15:0] dst_lit_val = oad_lit(dst_lit_in, lit_wide_in);

    assign src_if.mode    = src_mode_in;
    assign src_if.ptr_val = src_ptr_val;
    assign src_if.ofs_val = ofs_val;
    assign src_if.lit_val = src_lit_val;
    assign src_if.dec     = src_dec_in;
    assign dst_if.mode    = dst_mode_in;
    assign dst_if.ptr_val = dst_ptr_val;
    assign dst_if.ofs_val = ofs_val;
    assign dst_if.lit_val = dst_lit_val;
    assign dst_if.dec     = dst_dec_in;

    oad_ea_calc u_src (.p(src_if.calc));
    oad_ea_calc u_dst (.p(dst_if.calc));

    // next values of the answer strobes
    wire        valid_nxt   = accept;
    wire        err_nxt     = refuse;
    wire        src_wb_nxt  = accept && src_if.wb_en;
    wire        dst_wb_nxt  = accept && !is_dual && dst_if.wb_en;
    wire        x_valid_nxt = accept && is_dual && x_has;
    wire        y_valid_nxt = accept && is_dual && y_has;

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            valid_out    <= 1'b0;
            mode_err_out <= 1'b0;
        end
        else
        begin
            valid_out    <= valid_nxt;
            mode_err_out <= err_nxt;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            src_ea_out <= oad_pkg::RESET_ADDR;
        end
        else
        begin
            src_ea_out <= src_if.ea;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            dst_ea_out <= oad_pkg::RESET_ADDR;
        end
        else
        begin
            dst_ea_out <= dst_if.ea;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            src_wb_out     <= 1'b0;
            src_wb_idx_out <= 4'h0;
            src_wb_val_out <= oad_pkg::RESET_ADDR;
        end
        else
        begin
            src_wb_out     <= src_wb_nxt;
            src_wb_idx_out <= src_ptr_in;
            src_wb_val_out <= src_if.ptr_upd;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            dst_wb_out     <= 1'b0;
            dst_wb_idx_out <= 4'h0;
            dst_wb_val_out <= oad_pkg::RESET_ADDR;
        end
        else
        begin
            dst_wb_out     <= dst_wb_nxt;
            dst_wb_idx_out <= dst_ptr_in;
            dst_wb_val_out <= dst_if.ptr_upd;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            x_rd_valid_out <= 1'b0;
            x_rd_addr_out  <= oad_pkg::RESET_ADDR;
        end
        else
        begin
            x_rd_valid_out <= x_valid_nxt;
            x_rd_addr_out  <= x_addr;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            y_rd_valid_out <= 1'b0;
            y_rd_addr_out  <= oad_pkg::RESET_ADDR;
        end
        else
        begin
            y_rd_valid_out <= y_valid_nxt;
            y_rd_addr_out  <= y_addr;
        end
    end
endmodule : oad_decode

// ---- rtl/oad_pkg.sv ----
package oad_pkg;
    localparam int DATA_W  = 16;
    localparam int REG_W   = 4;
    localparam int NUM_REG = 16;
    localparam int LIT8_W  = 8;
    localparam int LIT16_W = 16;
    localparam int PRE_W   = 2;

    // operand addressing modes, encoded as a 3-bit field from decode
    localparam logic [2:0] MODE_DIRECT   = 3'h0;
    localparam logic [2:0] MODE_IND      = 3'h1;
    localparam logic [2:0] MODE_POSTMOD  = 3'h2;
    localparam logic [2:0] MODE_PREMOD   = 3'h3;
    localparam logic [2:0] MODE_INDEXED  = 3'h4;
    localparam logic [2:0] MODE_LITOFF   = 3'h5;
    localparam logic [2:0] MODE_LIT8     = 3'h6;
    localparam logic [2:0] MODE_LIT16    = 3'h7;

    // instruction classes
    localparam logic [1:0] CLASS_MCU     = 2'h0;
    localparam logic [1:0] CLASS_MOVE    = 2'h1;
    localparam logic [1:0] CLASS_ACC     = 2'h2;
    localparam logic [1:0] CLASS_DUAL    = 2'h3;

    // permitted mode masks, bit n set = mode n allowed
    localparam logic [7:0] ALLOW_MCU     = 8'h0F;
    localparam logic [7:0] ALLOW_MOVE    = 8'hFF;
    localparam logic [7:0] ALLOW_ACC     = 8'hFF;
    localparam logic [7:0] ALLOW_DUAL    = 8'h07;

    // prefetch pointer register numbers
    localparam logic [3:0] PF_PTR_A      = 4'h8;
    localparam logic [3:0] PF_PTR_B      = 4'h9;
    localparam logic [3:0] PF_PTR_C      = 4'hA;
    localparam logic [3:0] PF_PTR_D      = 4'hB;

    localparam logic [15:0] RESET_ADDR   = 16'h0000;
    localparam logic [15:0] STEP_WORD    = 16'h0002;
endpackage : oad_pkg

// ---- rtl/oad_ea_if.sv ----
`timescale 1ns/1ps
interface oad_ea_if;
    logic [2:0]  mode;
    logic [15:0] ptr_val;
    logic [15:0] ofs_val;
    logic [15:0] lit_val;
    logic        dec;
    logic [15:0] ea;
    logic [15:0] ptr_upd;
    logic        wb_en;
    modport calc (input mode, ptr_val, ofs_val, lit_val, dec, output ea, ptr_upd, wb_en);
    modport user (output mode, ptr_val, ofs_val, lit_val, dec, input ea, ptr_upd, wb_en);
endinterface : oad_ea_if

// ---- rtl/oad_ea_calc.sv ----
`timescale 1ns/1ps
module oad_ea_calc
(
    oad_ea_if.calc p
);
    wire [15:0] step_w  = p.dec ? (16'h0000 - oad_pkg::STEP_WORD) : oad_pkg::STEP_WORD;
    wire [15:0] sum_idx = p.ptr_val + p.ofs_val;
    wire [15:0] sum_lit = p.ptr_val + p.lit_val;
    wire [15:0] stepped = p.ptr_val + step_w;

    always_comb
    begin
        p.ea      = p.ptr_val;
        p.ptr_upd = p.ptr_val;
        p.wb_en   = 1'b0;
        case (p.mode)
            oad_pkg::MODE_DIRECT:  p.ea = p.ptr_val;
            oad_pkg::MODE_IND:     p.ea = p.ptr_val;
            oad_pkg::MODE_POSTMOD:
            begin
                p.ea      = p.ptr_val;
                p.ptr_upd = stepped;
                p.wb_en   = 1'b1;
            end
            oad_pkg::MODE_PREMOD:
            begin
                p.ea      = stepped;
                p.ptr_upd = stepped;
                p.wb_en   = 1'b1;
            end
            oad_pkg::MODE_INDEXED: p.ea = sum_idx;
            oad_pkg::MODE_LITOFF:  p.ea = sum_lit;
            oad_pkg::MODE_LIT8:    p.ea = p.lit_val;
            oad_pkg::MODE_LIT16:   p.ea = p.lit_val;
            default:               p.ea = p.ptr_val;
        endcase
    end
endmodule : oad_ea_calc

// ---- testbench/oad_decode_props.sv ----
`timescale 1ns/1ps
module oad_decode_props
(
    input wire logic         ref_clk_in,
    input wire logic         arst_n_in,
    input wire logic         issue_in,
    input wire logic [1:0]   iclass_in,
    input wire logic [2:0]   src_mode_in,
    input wire logic [2:0]   dst_mode_in,
    input wire logic [3:0]   src_ptr_in,
    input wire logic [3:0]   dst_ptr_in,
    input wire logic [3:0]   offset_register_field_in,
    input wire logic [3:0]   pf_ptr0_in,
    input wire logic [3:0]   pf_ptr1_in,
    input wire logic [255:0] wreg_in,
    input wire logic         valid_out,
    input wire logic         mode_err_out,
    input wire logic [15:0]  src_ea_out,
    input wire logic [15:0]  dst_ea_out,
    input wire logic         src_wb_out,
    input wire logic         dst_wb_out,
    input wire logic         x_rd_valid_out,
    input wire logic [15:0]  x_rd_addr_out,
    input wire logic         y_rd_valid_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    function automatic logic [15:0] wr(logic [255:0] w, logic [3:0] i);
        return w[i*16 +: 16];
    endfunction : wr
    wire mov_req  = issue_in && iclass_in == 2'h1;
    wire dual_req = issue_in && iclass_in == 2'h3 && src_mode_in < 3'h3;
    a_answer_once: assert property (issue_in |=> valid_out != mode_err_out)
        else $error("request without exactly one answer");
    a_idle_quiet: assert property (!issue_in |=> !valid_out && !mode_err_out)
        else $error("answer without request");
    a_err_quiet: assert property (mode_err_out |-> !(src_wb_out || dst_wb_out ||
        x_rd_valid_out || y_rd_valid_out)) else $error("strobe on refusal");
    a_mcu_subset: assert property (issue_in && iclass_in == 2'h0 && src_mode_in[2]
        |=> mode_err_out) else $error("mcu mode not refused");
    a_dual_subset: assert property (issue_in && iclass_in == 2'h3 && src_mode_in > 3'h2
        |=> mode_err_out) else $error("dual mode not refused");
    a_pf_range: assert property (dual_req && pf_ptr0_in[3:2] != 2'b10 |=> mode_err_out)
        else $error("bad prefetch pointer accepted");
    a_x_route: assert property (dual_req && pf_ptr0_in[3:1] == 3'b100 &&
        pf_ptr1_in[3:1] == 3'b101 |=> x_rd_valid_out && y_rd_valid_out &&
        x_rd_addr_out == wr($past(wreg_in), $past(pf_ptr0_in)))
        else $error("x prefetch misrouted");
    a_indexed_sum: assert property (mov_req && src_mode_in == 3'h4 |=> valid_out &&
        src_ea_out == wr($past(wreg_in), $past(src_ptr_in)) +
        wr($past(wreg_in), $past(offset_register_field_in)))
        else $error("indexed source wrong");
    a_dst_indexed: assert property (mov_req && dst_mode_in == 3'h4 |=>
        dst_ea_out == wr($past(wreg_in), $past(dst_ptr_in)) +
        wr($past(wreg_in), $past(offset_register_field_in)))
        else $error("indexed dest wrong");
    a_post_step: assert property (mov_req && src_mode_in == 3'h2 |=> src_wb_out &&
        src_ea_out == wr($past(wreg_in), $past(src_ptr_in))) else $error("post-mod wrong");
    c_move: cover property (mov_req ##1 valid_out);
    c_dual: cover property (dual_req ##1 x_rd_valid_out);
    c_err: cover property (issue_in ##1 mode_err_out);
endmodule : oad_decode_props
bind oad_decode oad_decode_props u_props (.*);

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic ref_clk_in = 1'b0, arst_n_in = 1'b0, issue_in = 1'b0, lit_wide_in = 1'b0;
    logic src_dec_in = 1'b0, dst_dec_in = 1'b0;
    logic [1:0]   iclass_in = 2'h0;
    logic [2:0]   src_mode_in = 3'h0, dst_mode_in = 3'h0;
    logic [3:0]   src_ptr_in = 4'h0, dst_ptr_in = 4'h0, offset_register_field_in = 4'h0;
    logic [3:0]   pf_ptr0_in = 4'h0, pf_ptr1_in = 4'h0;
    logic [15:0]  src_lit_in = 16'h0000, dst_lit_in = 16'h0000;
    logic [255:0] wreg_in = '0;
    logic valid_out, mode_err_out, src_wb_out, dst_wb_out, x_rd_valid_out, y_rd_valid_out;
    logic [3:0]   src_wb_idx_out, dst_wb_idx_out;
    logic [15:0]  src_ea_out, dst_ea_out, src_wb_val_out, dst_wb_val_out;
    logic [15:0]  x_rd_addr_out, y_rd_addr_out;
    integer       seed = 85, err_count = 0, checks = 0, n, k;
    logic [31:0]  r, l;
    logic [255:0] w;
    logic [7:0]   m;
    logic         e_err, lw, e_swb, e_dwb;
    oad_decode uut (.*);
    always #10 ref_clk_in = ~ref_clk_in;
    function automatic logic [15:0] wr(input logic [3:0] i);
        return w[i*16 +: 16];
    endfunction : wr
    function automatic logic [15:0] step(input logic [3:0] p, input logic dn);
        return dn ? wr(p) - 16'h0002 : wr(p) + 16'h0002;
    endfunction : step
    function automatic logic [15:0] ea(input logic [2:0] md, input logic [3:0] p,
                                       input logic [15:0] lt, input logic dn);
        logic [15:0] li;
        li = lw ? lt : {8'h00, lt[7:0]};
        case (md)
            3'h3:    return step(p, dn);
            3'h4:    return wr(p) + wr(r[11:8]);
            3'h5:    return wr(p) + li;
            3'h6,
            3'h7:    return li;
            default: return wr(p);
        endcase
    endfunction : ea
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (10) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        for (n = 0; n < 800; n++)
        begin
            @(posedge ref_clk_in);
            r = $random(seed);
            l = $random(seed);
            for (k = 0; k < 8; k++) w[k*32 +: 32] = $random(seed);
            lw = (r[4:2] == 3'h7) || (r[4:2] != 3'h6 && r[27]);
            issue_in <= 1'b1;
            {iclass_in, src_mode_in, dst_mode_in} <= {r[1:0], r[4:2], r[7:5]};
            {src_ptr_in, dst_ptr_in, offset_register_field_in} <= r[19:8];
            pf_ptr0_in <= (r[22:20] == 3'h0) ? 4'h5 : {3'b100, r[23]};
            pf_ptr1_in <= {3'b101, r[24]};
            {src_dec_in, dst_dec_in, lit_wide_in} <= {r[25], r[26], lw};
            {dst_lit_in, src_lit_in} <= l;
            wreg_in <= w;
            @(posedge ref_clk_in);
            #1;
            m = (r[1:0] == 2'h0) ? 8'h0F : (r[1:0] == 2'h3) ? 8'h07 : 8'hFF;
            e_err = !m[r[4:2]] || (r[1:0] != 2'h3 && !m[r[7:5]]) ||
                    (r[1:0] == 2'h3 && r[22:20] == 3'h0);
            chk("valid", {15'h0, !e_err}, {15'h0, valid_out});
            chk("mode_err", {15'h0, e_err}, {15'h0, mode_err_out});
            if (!e_err && r[1:0] != 2'h3)
            begin
                chk("src_ea", ea(r[4:2], r[19:16], l[15:0], r[25]), src_ea_out);
                if (r[7:6] != 2'b11 || lw == r[5])
                    chk("dst_ea", ea(r[7:5], r[15:12], l[31:16], r[26]), dst_ea_out);
            end
            e_swb = !e_err && r[4:3] == 2'b01;
            e_dwb = !e_err && r[1:0] != 2'h3 && r[7:6] == 2'b01;
            chk("src_wb", {15'h0, e_swb}, {15'h0, src_wb_out});
            chk("dst_wb", {15'h0, e_dwb}, {15'h0, dst_wb_out});
            if (e_swb)
            begin
                chk("src_wb_idx", {12'h000, r[19:16]}, {12'h000, src_wb_idx_out});
                chk("src_wb_val", step(r[19:16], r[25]), src_wb_val_out);
            end
            if (e_dwb)
            begin
                chk("dst_wb_idx", {12'h000, r[15:12]}, {12'h000, dst_wb_idx_out});
                chk("dst_wb_val", step(r[15:12], r[26]), dst_wb_val_out);
            end
            chk("x_valid", {15'h0, !e_err && r[1:0] == 2'h3}, {15'h0, x_rd_valid_out});
            chk("y_valid", {15'h0, !e_err && r[1:0] == 2'h3}, {15'h0, y_rd_valid_out});
            if (!e_err && r[1:0] == 2'h3)
            begin
                chk("x_addr", wr({3'b100, r[23]}), x_rd_addr_out);
                chk("y_addr", wr({3'b101, r[24]}), y_rd_addr_out);
            end
        end
        @(posedge ref_clk_in);
        issue_in <= 1'b0;
        $display("random operand decode test done");
        end_of_test;
    end
endmodule : testbench
